/* File: pei_pkg.sv */
// constants, codes and carriers for the processor external interface block
package pei_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int ASI_W  = 8;
  localparam int MASK_W = 4;
  localparam int LVL_W  = 4;
  localparam int CC_W   = 2;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_ADDR    = 8'h04;
  localparam logic [7:0] OFF_ASIMASK = 8'h08;
  localparam logic [7:0] OFF_WDATA   = 8'h0C;
  localparam logic [7:0] OFF_CMD     = 8'h10;
  localparam logic [7:0] OFF_LDATA   = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_COND    = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ET_BIT   = 0;
  localparam int CTRL_PIL_LSB  = 4;
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_SYNC_BIT  = 2;
  localparam int AM_ASI_LSB    = 0;
  localparam int AM_MASK_LSB   = 8;
  localparam int COND_F_LSB    = 0;
  localparam int COND_A_LSB    = 4;
  localparam int ST_TRAP_BIT   = 12;

  // ----------------------------------------------------------------
  // reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [LVL_W-1:0]  LVL_NONE   = 4'h0;
  localparam logic [LVL_W-1:0]  LVL_NMI    = 4'hF;
  localparam logic [MASK_W-1:0] MASK_RST   = 4'hF;
  localparam logic [ADDR_W-1:0] BOOT_ADDR  = 32'h0000_0000;
  localparam logic [ASI_W-1:0]  BOOT_ASI   = 8'h09;
  localparam logic [7:0]        TSET_BYTE  = 8'hFF;

  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_EXEC  = 2'b01,
    MODE_ERROR = 2'b10
  } pei_mode_t;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_READ  = 2'b01,
    MS_WRITE = 2'b10
  } pei_mstate_t;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_WRITE = 2'b01,
    OP_SWAP  = 2'b10,
    OP_TSET  = 2'b11
  } pei_op_t;

  typedef enum logic [2:0] {
    CAUSE_NONE   = 3'b000,
    CAUSE_IRQ    = 3'b001,
    CAUSE_ACCESS = 3'b010,
    CAUSE_FLOAT  = 3'b011,
    CAUSE_AUX    = 3'b100
  } pei_cause_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ASI_W-1:0]  asi;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] mask;   // msb selects byte 0 (bits 31:24)
    logic              we;
    logic              sync;
  } pei_mem_req_t;

endpackage : pei_pkg

/* File: pei_core.sv */
// processor external interface: mode control, traps, interrupts, memory port, apb registers
`timescale 1ns/10ps
`default_nettype none

module pei_core
  import pei_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // asynchronous system pins
  input  wire logic              system_reset_request,
  input  wire logic [LVL_W-1:0]  interrupt_level_in,
  output logic                   error_out,
  // memory port
  output logic                   mem_req_valid,
  output var pei_mem_req_t       mem_req,
  input  wire logic              mem_ack,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic              mem_fault,
  output logic                   atomic_word_lock,
  output logic                   atomic_byte_lock,
  // float unit and coprocessor
  input  wire logic              float_unit_present,
  input  wire logic              float_unit_fault,
  input  wire logic [CC_W-1:0]   float_branch_code,
  input  wire logic              aux_unit_present,
  input  wire logic              aux_unit_fault,
  input  wire logic [CC_W-1:0]   aux_branch_code,
  // trap report
  output logic                   trap_taken,
  output var pei_cause_t         trap_cause,
  output logic      [LVL_W-1:0]  trap_level
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // condition mask indexed by a 2-bit branch code
  function automatic logic cond_hit(input logic [3:0] m, input logic [CC_W-1:0] cc);
    return m[cc];
  endfunction : cond_hit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [LVL_W-1:0] irl_s1_q, irl_s2_q;
  logic             rst_s1_q, rst_s2_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irl_s1_q <= LVL_NONE;
      irl_s2_q <= LVL_NONE;
    end else begin
      irl_s1_q <= interrupt_level_in;
      irl_s2_q <= irl_s1_q;
    end
  end

  // held in reset request until the pin is seen low twice
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
    end else begin
      rst_s1_q <= system_reset_request;
      rst_s2_q <= rst_s1_q;
    end
  end

  AST_IRL_SYNC: assert property ($stable(interrupt_level_in)[*3] |-> irl_s2_q == interrupt_level_in)
    else $error("interrupt level not through synchroniser in two cycles");

  // ----------------------------------------------------------------
  // apb decode and software registers
  // ----------------------------------------------------------------
  logic              wr_en, hit;
  logic              et_q;
  logic [LVL_W-1:0]  pil_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ASI_W-1:0]  asi_q;
  logic [MASK_W-1:0] mask_q;
  logic [DATA_W-1:0] wdata_q, ldata_q;
  logic [7:0]        cond_q;
  logic              trap_flag_q, fault_q;
  pei_mode_t         mode_q;
  pei_mstate_t       ms_q;
  pei_op_t           op_q;
  logic              take_trap, take_irq, exc_now, mem_done, mem_bad;
  pei_cause_t        exc_cause;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign hit     = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_q  <= BOOT_ADDR;
      asi_q   <= BOOT_ASI;
      mask_q  <= MASK_RST;
      wdata_q <= '0;
      cond_q  <= '0;
      pil_q   <= LVL_NONE;
    end else if (wr_en) begin
      case (paddr)
        OFF_ADDR:    addr_q  <= pwdata;
        OFF_ASIMASK: begin
          asi_q  <= pwdata[AM_ASI_LSB +: ASI_W];
          mask_q <= pwdata[AM_MASK_LSB +: MASK_W];
        end
        OFF_WDATA:   wdata_q <= pwdata;
        OFF_COND:    cond_q  <= pwdata[7:0];
        OFF_CTRL:    pil_q   <= pwdata[CTRL_PIL_LSB +: LVL_W];
        default:     ;
      endcase
    end
  end

  // trap entry clears trap enable; it beats a simultaneous software write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      et_q <= 1'b0;
    else if (take_trap)
      et_q <= 1'b0;
    else if (wr_en && paddr == OFF_CTRL)
      et_q <= pwdata[CTRL_ET_BIT];
  end

  // sticky trap flag: write one to clear, a new trap wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      trap_flag_q <= 1'b0;
    else if (take_trap)
      trap_flag_q <= 1'b1;
    else if (wr_en && paddr == OFF_STATUS && pwdata[ST_TRAP_BIT])
      trap_flag_q <= 1'b0;
  end

  // read mux is combinational over flops and the unit pins so the slave answers with no wait state
  always_comb begin
    prdata = '0;
    case (paddr)
      OFF_CTRL:    prdata = {24'h0, pil_q, 3'h0, et_q};
      OFF_ADDR:    prdata = addr_q;
      OFF_ASIMASK: prdata = {20'h0, mask_q, asi_q};
      OFF_WDATA:   prdata = wdata_q;
      OFF_LDATA:   prdata = ldata_q;
      OFF_STATUS:  prdata = {12'h0, trap_level, trap_cause, trap_flag_q,
                             cond_hit(cond_q[COND_A_LSB +: 4], aux_branch_code),
                             cond_hit(cond_q[COND_F_LSB +: 4], float_branch_code),
                             aux_branch_code, float_branch_code, aux_unit_present, float_unit_present,
                             fault_q, (ms_q != MS_IDLE), mode_q};
      OFF_COND:    prdata = {24'h0, cond_q};
      default:     prdata = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // processor mode
  // ----------------------------------------------------------------
  assign mem_done  = mem_req_valid && mem_ack;
  assign mem_bad   = mem_done && mem_fault;
  assign exc_now   = mem_bad || float_unit_fault || aux_unit_fault;
  assign exc_cause = mem_bad ? CAUSE_ACCESS : (float_unit_fault ? CAUSE_FLOAT : CAUSE_AUX);
  assign take_irq  = et_q && ((irl_s2_q == LVL_NMI) || (irl_s2_q > pil_q));
  assign take_trap = (mode_q == MODE_EXEC) && !rst_s2_q && et_q && (exc_now || take_irq);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_RESET;
    end else begin
      case (mode_q)
        MODE_RESET: if (!rst_s2_q) mode_q <= MODE_EXEC;
        MODE_EXEC: begin
          if (rst_s2_q)
            mode_q <= MODE_RESET;
          else if (exc_now && !et_q)
            mode_q <= MODE_ERROR;
        end
        MODE_ERROR: if (rst_s2_q) mode_q <= MODE_RESET;
        default:    mode_q <= MODE_RESET;
      endcase
    end
  end

  assign error_out = (mode_q == MODE_ERROR);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trap_taken <= 1'b0;
      trap_cause <= CAUSE_NONE;
      trap_level <= LVL_NONE;
    end else begin
      trap_taken <= take_trap;
      if (take_trap) begin
        trap_cause <= exc_now ? exc_cause : CAUSE_IRQ;
        trap_level <= exc_now ? LVL_NONE : irl_s2_q;
      end
    end
  end

  sequence s_in_error;
    mode_q == MODE_ERROR && !rst_s2_q;
  endsequence

  AST_ERROR_HELD: assert property (s_in_error |=> error_out)
    else $error("error output dropped while halted");
  AST_RESET_CLEARS: assert property (rst_s2_q && mode_q != MODE_RESET |=> mode_q == MODE_RESET && !error_out)
    else $error("reset request did not reach reset state");
  AST_ERR_ENTRY: assert property (mode_q == MODE_EXEC && !rst_s2_q && !et_q && exc_now |=> s_in_error or
                                  (mode_q == MODE_ERROR))
    else $error("exception with traps disabled did not halt");
  AST_IRQ_TAKE: assert property (mode_q == MODE_EXEC && !rst_s2_q && !exc_now && take_irq
                                 |=> trap_taken && trap_cause == CAUSE_IRQ && trap_level == $past(irl_s2_q))
    else $error("eligible interrupt not taken");
  AST_IRQ_GATED: assert property (!et_q |=> !trap_taken)
    else $error("trap taken while traps disabled");
  AST_FLOAT_TRAP: assert property (mode_q == MODE_EXEC && !rst_s2_q && et_q && float_unit_fault && !mem_bad
                                   |=> trap_taken && trap_cause == CAUSE_FLOAT)
    else $error("float fault did not trap");

  // ----------------------------------------------------------------
  // memory access engine
  // ----------------------------------------------------------------
  logic start_sw, start_boot;
  assign start_sw   = wr_en && paddr == OFF_CMD && ms_q == MS_IDLE && mode_q == MODE_EXEC;
  assign start_boot = (mode_q == MODE_RESET) && !rst_s2_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_q          <= MS_IDLE;
      op_q          <= OP_READ;
      mem_req_valid <= 1'b0;
      mem_req       <= '0;
    end else begin
      case (ms_q)
        MS_IDLE: begin
          if (start_boot) begin
            op_q          <= OP_READ;
            mem_req_valid <= 1'b1;
            mem_req       <= '{BOOT_ADDR, BOOT_ASI, '0, MASK_RST, 1'b0, 1'b0};
            ms_q          <= MS_READ;
          end else if (start_sw) begin
            op_q          <= pei_op_t'(pwdata[CMD_OP_LSB +: 2]);
            mem_req_valid <= 1'b1;
            mem_req       <= '{addr_q, asi_q, wdata_q, mask_q,
                               pwdata[CMD_OP_LSB +: 2] == OP_WRITE, pwdata[CMD_SYNC_BIT]};
            ms_q          <= (pwdata[CMD_OP_LSB +: 2] == OP_WRITE) ? MS_WRITE : MS_READ;
          end
        end
        MS_READ: if (mem_ack) begin
          if (!mem_fault && (op_q == OP_SWAP || op_q == OP_TSET)) begin
            mem_req.we    <= 1'b1;
            mem_req.wdata <= (op_q == OP_TSET) ? {4{TSET_BYTE}} : wdata_q;
            ms_q          <= MS_WRITE;
          end else begin
            mem_req_valid <= 1'b0;
            ms_q          <= MS_IDLE;
          end
        end
        MS_WRITE: if (mem_ack) begin
          mem_req_valid <= 1'b0;
          ms_q          <= MS_IDLE;
        end
        default: ms_q <= MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ldata_q <= '0;
      fault_q <= 1'b0;
    end else if (mem_done) begin
      fault_q <= mem_fault;
      if (!mem_req.we)
        ldata_q <= mem_rdata;
    end
  end

  assign atomic_word_lock = mem_req_valid && op_q == OP_SWAP;
  assign atomic_byte_lock = mem_req_valid && op_q == OP_TSET;

  sequence s_atomic_read;
    mem_done && !mem_fault && !mem_req.we && (op_q == OP_SWAP || op_q == OP_TSET);
  endsequence

  AST_FAULT_FLAG: assert property (mem_done |=> fault_q == $past(mem_fault))
    else $error("access fault flag not updated from access");
  AST_LOCK_SPAN: assert property (s_atomic_read |=> mem_req_valid && mem_req.we &&
                                  (atomic_word_lock || atomic_byte_lock))
    else $error("atomic lock not held into write half");
  AST_BOOT_FETCH: assert property (start_boot && ms_q == MS_IDLE |=> mem_req_valid && !mem_req.we &&
                                   mem_req.addr == BOOT_ADDR && mem_req.asi == BOOT_ASI)
    else $error("boot fetch not issued at address zero, space nine");
  AST_TSET_DATA: assert property (s_atomic_read and (op_q == OP_TSET) |=> mem_req.wdata == {4{TSET_BYTE}})
    else $error("test-and-set wrote wrong data");

endmodule : pei_core

`default_nettype wire

/* File: pei_mem_model.sv */
// memory system, float unit and coprocessor partner model
`timescale 1ns/10ps
`default_nettype none
module pei_mem_model
  import pei_pkg::*;
(
  // clock and pacing
  input  wire logic              sys_clk,
  input  wire logic [3:0]        slow,
  // memory port
  input  wire logic              mem_req_valid,
  input  wire pei_mem_req_t      mem_req,
  output logic                   mem_ack,
  output logic      [DATA_W-1:0] mem_rdata,
  output logic                   mem_fault,
  // attached units
  output logic                   float_unit_present,
  output logic                   aux_unit_present
);
  // ----------------------------------------------------------------
  // word store
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [16];
  logic [3:0]        wait_q = 4'h0;
  logic [DATA_W-1:0] last_q = 32'h0;
  logic [DATA_W-1:0] merged;
  logic [3:0]        idx;

  initial for (int i = 0; i < 16; i++) mem_q[i] = 32'hA5A5_0000 + i;
  assign float_unit_present = 1'b1;
  assign aux_unit_present   = 1'b1;
  assign idx = mem_req.addr[5:2];
  assign mem_ack = mem_req_valid && (wait_q == slow);
  // off the ack cycle the lines carry junk, so stale values never look right
  assign mem_rdata = mem_ack ? mem_q[idx] : ~last_q;
  assign mem_fault = mem_ack ? mem_req.addr[31] : ~mem_req.addr[31];
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[31-8*b -: 8] = mem_req.mask[3-b] ? mem_req.wdata[31-8*b -: 8] : mem_q[idx][31-8*b -: 8];
    end
  end
  // one request at a time, so an ordered store always follows earlier ones
  always @(posedge sys_clk) begin
    wait_q <= (mem_req_valid && !mem_ack) ? wait_q + 4'h1 : 4'h0;
    if (mem_ack) begin
      last_q <= mem_rdata;
      if (mem_req.we && !mem_req.addr[31]) mem_q[idx] <= merged;
    end
  end
endmodule : pei_mem_model
`default_nettype wire

/* File: pei_core_tb.sv */
// self-checking testbench for the processor external interface core
`timescale 1ns/10ps
`default_nettype none
module pei_core_tb
  import pei_pkg::*;
;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  logic              sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0]        paddr;
  logic [DATA_W-1:0] pwdata, prdata, mem_rdata, rdv;
  logic              system_reset_request, error_out, mem_req_valid, mem_ack, mem_fault;
  logic [LVL_W-1:0]  interrupt_level_in, trap_level, lvl_seen;
  logic [ASI_W-1:0]  asi_seen;
  pei_mem_req_t      mem_req;
  logic              atomic_word_lock, atomic_byte_lock, trap_taken, wl_seen, bl_seen, sync_seen;
  logic              float_unit_present, float_unit_fault, aux_unit_present, aux_unit_fault;
  logic [CC_W-1:0]   float_branch_code, aux_branch_code;
  pei_cause_t        trap_cause, cause_seen;
  logic [3:0]        slow;
  int                fail_count, comparisons, trap_n, n0;

  pei_core DUT (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .system_reset_request, .interrupt_level_in, .error_out, .mem_req_valid, .mem_req, .mem_ack, .mem_rdata,
    .mem_fault, .atomic_word_lock, .atomic_byte_lock, .float_unit_present, .float_unit_fault,
    .float_branch_code, .aux_unit_present, .aux_unit_fault, .aux_branch_code, .trap_taken, .trap_cause,
    .trap_level);
  pei_mem_model u_mem (.sys_clk, .slow, .mem_req_valid, .mem_req, .mem_ack, .mem_rdata, .mem_fault,
    .float_unit_present, .aux_unit_present);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (trap_taken === 1'b1) begin
      trap_n++;
      cause_seen = trap_cause;
      lvl_seen = trap_level;
    end
    if (mem_req_valid === 1'b1) begin
      asi_seen = mem_req.asi;
      if (mem_req.we === 1'b1) sync_seen = mem_req.sync;
      wl_seen |= atomic_word_lock;
      bl_seen |= atomic_byte_lock;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic hang(input string what);
    chk(what, 32'h0, 32'h1);
    give_verdict();
  endtask : hang
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  // entered just after a rising edge; leaves one idle edge so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("pready");
    rdv = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rdv);
  endtask : rd
  task automatic cmd(input logic [2:0] c);
    int n;
    wr(OFF_CMD, {29'h0, c});
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rdv[2] !== 1'b0 && n < 30);
    if (rdv[2] !== 1'b0) hang("busy");
  endtask : cmd
  task automatic wait_boot();
    for (int n = 0; n < 20 && mem_req_valid !== 1'b1; n++) @(posedge sys_clk);
    if (mem_req_valid !== 1'b1) hang("boot start");
    chk("boot valid", 32'h1, 32'(mem_req_valid));
    chk("boot addr", BOOT_ADDR, mem_req.addr);
    chk("boot asi", 32'(BOOT_ASI), 32'(mem_req.asi));
    for (int n = 0; n < 20 && mem_req_valid !== 1'b0; n++) @(posedge sys_clk);
    if (mem_req_valid !== 1'b0) hang("boot end");
    tick(1);
  endtask : wait_boot

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_boot();
    wait_boot();
    rd(OFF_LDATA, "boot data", 32'hA5A5_0000);
    rd(OFF_ASIMASK, "asimask", 32'h0000_0F09);
    rd(OFF_STATUS, "status", 32'h0000_0031);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 8'h06 : 8'h20, 32'h0);
      chk("unmapped", 32'h1, {rdv[31:1], serr});
    end
  endtask : t_boot
  task automatic t_mem();
    for (int s = 0; s < 2; s++) begin
      slow <= s ? 4'h3 : 4'h0;
      wr(OFF_ADDR, s ? 32'h8 : 32'h4);
      wr(OFF_ASIMASK, s ? 32'h0121 : 32'h0821);
      wr(OFF_WDATA, 32'h1122_3344);
      cmd({1'(s), OP_WRITE});
      chk("ordered", 32'(s), 32'(sync_seen));
      cmd({1'b0, OP_READ});
      chk("no fault", 32'h0, 32'(rdv[3]));
      chk("asi", 32'h21, 32'(asi_seen));
      rd(OFF_LDATA, "masked", s ? 32'hA5A5_0044 : 32'h11A5_0001);
    end
  endtask : t_mem
  task automatic t_fault();
    wr(OFF_CTRL, 32'h1);
    wr(OFF_ADDR, 32'h8000_0004);
    wr(OFF_ASIMASK, 32'h0F09);
    n0 = trap_n;
    cmd({1'b0, OP_WRITE});
    chk("fault flag", 32'h1, 32'(rdv[3]));
    chk("fault trap", 32'(n0 + 1), 32'(trap_n));
    chk("fault cause", 32'(CAUSE_ACCESS), 32'(cause_seen));
    wr(OFF_ADDR, 32'h4);
    cmd({1'b0, OP_READ});
    chk("fault clear", 32'h0, 32'(rdv[3]));
    rd(OFF_LDATA, "kept", 32'h11A5_0001);
  endtask : t_fault
  task automatic t_atomic();
    slow <= 4'h2;
    wr(OFF_ADDR, 32'hC);
    wr(OFF_WDATA, 32'hDEAD_BEEF);
    wl_seen = 1'b0;
    bl_seen = 1'b0;
    cmd({1'b0, OP_SWAP});
    rd(OFF_LDATA, "swap old", 32'hA5A5_0003);
    chk("word lock", 32'h2, {30'h0, wl_seen, bl_seen});
    wr(OFF_ASIMASK, 32'h0409);
    wl_seen = 1'b0;
    bl_seen = 1'b0;
    cmd({1'b0, OP_TSET});
    chk("byte lock", 32'h1, {30'h0, wl_seen, bl_seen});
    cmd({1'b0, OP_READ});
    rd(OFF_LDATA, "tset data", 32'hDEFF_BEEF);
  endtask : t_atomic
  task automatic t_irq();
    logic [11:0] tbl [5] = '{12'h515, 12'h516, 12'hF1F, 12'hF0F, 12'h010};
    logic        hit;
    for (int i = 0; i < 5; i++) begin
      wr(OFF_CTRL, 32'(tbl[i][11:4]));
      n0 = trap_n;
      interrupt_level_in <= tbl[i][3:0];
      tick(8);
      interrupt_level_in <= LVL_NONE;
      tick(4);
      hit = tbl[i][4] && (tbl[i][3:0] == LVL_NMI || tbl[i][3:0] > tbl[i][11:8]);
      chk("irq count", 32'(hit), 32'(trap_n - n0));
      if (hit) chk("irq level", 32'(tbl[i][3:0]), 32'(lvl_seen));
    end
  endtask : t_irq
  task automatic t_units();
    for (int u = 0; u < 2; u++) begin
      wr(OFF_CTRL, 32'h1);
      n0 = trap_n;
      if (u) aux_unit_fault <= 1'b1;
      else float_unit_fault <= 1'b1;
      tick(1);
      aux_unit_fault <= 1'b0;
      float_unit_fault <= 1'b0;
      tick(3);
      chk("unit trap", 32'h1, 32'(trap_n - n0));
      chk("unit cause", u ? 32'(CAUSE_AUX) : 32'(CAUSE_FLOAT), 32'(cause_seen));
    end
    wr(OFF_COND, 32'h84);
    for (int c = 0; c < 4; c++) begin
      float_branch_code <= 2'(c);
      aux_branch_code <= 2'(3 - c);
      tick(2);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("codes", {24'h0, c == 0, c == 2, 2'(3 - c), 2'(c), 2'b11}, {24'h0, rdv[11:4]});
    end
  endtask : t_units
  task automatic t_error();
    wr(OFF_CTRL, 32'h0);
    float_unit_fault <= 1'b1;
    tick(1);
    float_unit_fault <= 1'b0;
    tick(6);
    chk("error high", 32'h1, 32'(error_out));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("error mode", 32'(MODE_ERROR), 32'(rdv[1:0]));
    chk("error held", 32'h1, 32'(error_out));
    system_reset_request <= 1'b1;
    tick(4);
    chk("error cleared", 32'h0, 32'(error_out));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("reset mode", 32'(MODE_RESET), 32'(rdv[1:0]));
    system_reset_request <= 1'b0;
    wait_boot();
  endtask : t_error

  initial begin
    fail_count = 0;
    comparisons = 0;
    trap_n = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    system_reset_request = 1'b0;
    interrupt_level_in = 4'h0;
    float_unit_fault = 1'b0;
    aux_unit_fault = 1'b0;
    float_branch_code = 2'h0;
    aux_branch_code = 2'h0;
    slow = 4'h0;
    tick(4);
    arst_n <= 1'b1;
    t_boot();
    t_mem();
    t_fault();
    t_atomic();
    t_irq();
    t_units();
    t_error();
    give_verdict();
  end
  initial begin
    #2500000;
    hang("watchdog");
  end
endmodule : pei_core_tb
`default_nettype wire
